// *** usbaec_defs.svh ***
// register offsets, field positions and codes for the usb address and control endpoint logic
`ifndef USBAEC_DEFS_SVH
`define USBAEC_DEFS_SVH
`define USBAEC_ADDR_OFS     8'h10
`define USBAEC_MODE_OFS     8'h12
`define USBAEC_ADDR_EN_BIT  7
`define USBAEC_SETUP_BIT    7
`define USBAEC_IN_BIT       6
`define USBAEC_OUT_BIT      5
`define USBAEC_ACK_BIT      4
`define USBAEC_MODE_NAK     4'h1
`define USBAEC_MODE_IDLE    4'h0
`define USBAEC_FIFO_BASE    8'hF8
`define USBAEC_FIFO_DEPTH   8
`define USBAEC_NUM_EP       3
`endif

// *** usbaec_pkg.sv ***
// types shared by the usb address and control endpoint logic
package usbaec_pkg;
   typedef enum logic [1:0] {
      USBAEC_PID_OUT   = 2'h0,
      USBAEC_PID_IN    = 2'h1,
      USBAEC_PID_SETUP = 2'h3
   } usbaec_pid_t;
   // token from the protocol engine front end
   typedef struct packed {
      logic        valid;
      usbaec_pid_t pid;
      logic [6:0]  addr;
      logic [1:0]  endp;
   } usbaec_token_t;
   // handshake decision back to the front end
   typedef struct packed {
      logic valid;
      logic ack;
      logic nak;
   } usbaec_hs_t;
   typedef enum logic [1:0] {
      USBAEC_ST_IDLE  = 2'h0,
      USBAEC_ST_TOKEN = 2'h1,
      USBAEC_ST_DATA  = 2'h3
   } usbaec_state_t;
endpackage

// *** usbaec_core.sv ***
// usb device address filter and control endpoint mode and status logic
// Summary of operation
// - hold a 7-bit device address and one address enable bit.
// - any reset and usb bus reset clear the address register to zero.
// - respond to traffic at the programmed address only while enable is set.
// - control endpoint is bidirectional with eight bytes at ram F8 to FF.
// - an unlocked mode register write clears those of the four event flags that hardware does not set in that cycle.
// - setup flag forced high from setup data until the transaction ends, acked or not; cpu cannot clear.
// - while setup flag is set, cpu writes to the endpoint buffer are blocked.
// - in flag set after the last packet of a valid in transaction.
// - out flag set after the last packet of a valid out transaction.
// - ack flag set when a transaction ends in ack, zero otherwise.
// - mode 0001 answers every control endpoint in or out token with nak.
// - mode 0001 still answers a setup token with ack.
// - one address serves three endpoints: control plus two data endpoints.
`timescale 1ns/1ps
`default_nettype none
`include "usbaec_defs.svh"
module usbaec_core (
   input  wire logic                   mclk,
   input  wire logic                   srst,
   input  wire logic                   usb_bus_reset,
   input  wire logic [7:0]             io_addr,
   input  wire logic [7:0]             io_wdata,
   input  wire logic                   io_wr,
   output logic      [7:0]             io_rdata,
   input  wire logic [7:0]             ram_addr,
   input  wire logic                   ram_wr_req,
   output logic                        ram_wr_allow,
   input  wire usbaec_pkg::usbaec_token_t tok,
   input  wire logic                   setup_data_start,
   input  wire logic                   xact_done,
   input  wire logic                   xact_acked,
   output usbaec_pkg::usbaec_hs_t      hs,
   output logic                        tok_match,
   output logic      [1:0]             tok_endp
);
   import usbaec_pkg::*;

   logic [7:0]    addr_q;
   logic [7:0]    mode_q;
   logic [7:0]    mode_d;
   logic [7:0]    rdata_q;
   logic          allow_q;
   usbaec_hs_t    hs_q;
   logic          match_q;
   logic [1:0]    endp_q;
   usbaec_state_t st_q;
   usbaec_state_t st_d;
   usbaec_pid_t   pid_q;
   logic          setup_lock_q;

   // decode of bus and token
   wire wr_addr   = io_wr && (io_addr == `USBAEC_ADDR_OFS);
   wire wr_mode   = io_wr && (io_addr == `USBAEC_MODE_OFS);
   wire addr_hit  = addr_q[`USBAEC_ADDR_EN_BIT] && (tok.addr == addr_q[6:0]);
   wire ep_ok     = (32'(tok.endp) < `USBAEC_NUM_EP);
   wire tok_ok    = tok.valid && addr_hit && ep_ok;
   wire ep0_tok   = tok_ok && (tok.endp == 2'h0);
   wire nak_mode  = (mode_q[3:0] == `USBAEC_MODE_NAK);
   wire in_fifo   = (ram_addr >= `USBAEC_FIFO_BASE);
   wire mode_lock = setup_lock_q;
   wire end_ep0   = xact_done && (st_q == USBAEC_ST_DATA || st_q == USBAEC_ST_TOKEN);
   wire ack_end   = end_ep0 && xact_acked;

   // address register; bus reset shares the clear with system reset
   always_ff @(posedge mclk) begin
      if (srst || usb_bus_reset) begin
         addr_q <= 8'h00;
      end else if (wr_addr) begin
         addr_q <= io_wdata;
      end
   end

   // transaction tracking for the control endpoint
   always_comb begin
      st_d = st_q;
      case (st_q)
         USBAEC_ST_IDLE:  if (ep0_tok) st_d = USBAEC_ST_TOKEN;
         USBAEC_ST_TOKEN: if (xact_done) st_d = USBAEC_ST_IDLE;
                          else if (setup_data_start) st_d = USBAEC_ST_DATA;
         USBAEC_ST_DATA:  if (xact_done) st_d = USBAEC_ST_IDLE;
         default:         st_d = USBAEC_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst || usb_bus_reset) begin
         st_q  <= USBAEC_ST_IDLE;
         pid_q <= USBAEC_PID_OUT;
      end else begin
         st_q <= st_d;
         if (ep0_tok) pid_q <= tok.pid;
      end
   end

   // setup lock spans setup data start up to the transaction end, acked or not
   always_ff @(posedge mclk) begin
      if (srst || usb_bus_reset) begin
         setup_lock_q <= 1'b0;
      end else if (st_q == USBAEC_ST_TOKEN && setup_data_start && pid_q == USBAEC_PID_SETUP) begin
         setup_lock_q <= 1'b1;
      end else if (end_ep0) begin
         setup_lock_q <= 1'b0;
      end
   end

   // mode register next value; hardware sets win over a write clear
   always_comb begin
      mode_d = mode_q;
      if (wr_mode && !mode_lock) begin
         mode_d[7:4] = 4'h0;
         mode_d[3:0] = (io_wdata[3:0] == `USBAEC_MODE_NAK) ? io_wdata[3:0] : `USBAEC_MODE_IDLE;
      end
      if (mode_lock || (st_q == USBAEC_ST_TOKEN && setup_data_start && pid_q == USBAEC_PID_SETUP))
         mode_d[`USBAEC_SETUP_BIT] = 1'b1;
      if (end_ep0 && pid_q == USBAEC_PID_IN && xact_acked)
         mode_d[`USBAEC_IN_BIT] = 1'b1;
      if (end_ep0 && pid_q == USBAEC_PID_OUT && xact_acked)
         mode_d[`USBAEC_OUT_BIT] = 1'b1;
      if (end_ep0)
         mode_d[`USBAEC_ACK_BIT] = xact_acked;
   end

   always_ff @(posedge mclk) begin
      if (srst || usb_bus_reset) begin
         mode_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
      end
   end

   // handshake choice: nak data, ack setup; other modes left silent
   always_ff @(posedge mclk) begin
      if (srst) begin
         hs_q    <= '0;
         match_q <= 1'b0;
         endp_q  <= 2'h0;
      end else begin
         hs_q.valid <= ep0_tok && nak_mode;
         hs_q.nak   <= ep0_tok && nak_mode && (tok.pid != USBAEC_PID_SETUP);
         hs_q.ack   <= ep0_tok && nak_mode && (tok.pid == USBAEC_PID_SETUP);
         match_q    <= tok_ok;
         endp_q     <= tok.endp;
      end
   end

   // buffer write gate; a setup in progress must not be overwritten
   always_ff @(posedge mclk) begin
      if (srst) begin
         allow_q <= 1'b0;
      end else begin
         allow_q <= ram_wr_req && !(in_fifo && mode_d[`USBAEC_SETUP_BIT]);
      end
   end

   // read mux; unmapped offsets read zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= (io_addr == `USBAEC_ADDR_OFS) ? addr_q :
                    (io_addr == `USBAEC_MODE_OFS) ? mode_q : 8'h00;
      end
   end

   assign io_rdata     = rdata_q;
   assign ram_wr_allow = allow_q;
   assign hs           = hs_q;
   assign tok_match    = match_q;
   assign tok_endp     = endp_q;

   // checks
   nak_on_data_a: assert property (@(posedge mclk) disable iff (srst)
      (ep0_tok && nak_mode && tok.pid != USBAEC_PID_SETUP) |=> (hs.nak && !hs.ack))
      else $error("data token not nak in nak mode");
   ack_on_setup_a: assert property (@(posedge mclk) disable iff (srst)
      (ep0_tok && nak_mode && tok.pid == USBAEC_PID_SETUP) |=> (hs.ack && !hs.nak))
      else $error("setup token not acked in nak mode");
   addr_gate_a: assert property (@(posedge mclk) disable iff (srst)
      (!addr_q[7]) |=> !tok_match)
      else $error("match while address disabled");
   bus_reset_a: assert property (@(posedge mclk) disable iff (srst)
      usb_bus_reset |=> (addr_q == 8'h00 && mode_q == 8'h00))
      else $error("bus reset did not clear");
   wr_clear_a: assert property (@(posedge mclk) disable iff (srst || usb_bus_reset)
      (wr_mode && !mode_lock && !end_ep0 && !setup_data_start) |=> (mode_q[7:4] == 4'h0))
      else $error("unlocked write left flags");
   setup_hold_a: assert property (@(posedge mclk) disable iff (srst || usb_bus_reset)
      setup_lock_q |=> mode_q[7])
      else $error("setup flag dropped while locked");
   fifo_block_a: assert property (@(posedge mclk) disable iff (srst)
      (ram_wr_req && in_fifo && mode_d[7]) |=> !ram_wr_allow)
      else $error("fifo write allowed during setup");
   ack_flag_a: assert property (@(posedge mclk) disable iff (srst || usb_bus_reset)
      end_ep0 |=> (mode_q[4] == $past(xact_acked)))
      else $error("ack flag wrong at transaction end");
   in_flag_a: assert property (@(posedge mclk) disable iff (srst || usb_bus_reset)
      (end_ep0 && xact_acked && pid_q == USBAEC_PID_IN) |=> mode_q[6])
      else $error("in flag not set");
   out_flag_a: assert property (@(posedge mclk) disable iff (srst || usb_bus_reset)
      (end_ep0 && xact_acked && pid_q == USBAEC_PID_OUT) |=> mode_q[5])
      else $error("out flag not set");
   mode_code_a: assert property (@(posedge mclk) disable iff (srst)
      (mode_q[3:0] == 4'h0 || mode_q[3:0] == 4'h1))
      else $error("reserved mode code stored");
   ep_range_a: assert property (@(posedge mclk) disable iff (srst)
      (tok.valid && tok.endp == 2'h3) |=> !tok_match)
      else $error("match on endpoint 3");
   addr_load_a: assert property (@(posedge mclk) disable iff (srst || usb_bus_reset)
      wr_addr |=> (addr_q == $past(io_wdata)))
      else $error("address write not stored");
   setup_set_a: assert property (@(posedge mclk) disable iff (srst || usb_bus_reset)
      (st_q == USBAEC_ST_TOKEN && setup_data_start && pid_q == USBAEC_PID_SETUP)
      |=> (setup_lock_q && mode_q[`USBAEC_SETUP_BIT]))
      else $error("setup data start did not lock");
   locked_write_a: assert property (@(posedge mclk) disable iff (srst || usb_bus_reset)
      (wr_mode && mode_lock) |=> (mode_q[3:0] == $past(mode_q[3:0])))
      else $error("locked write changed mode code");
   fifo_free_a: assert property (@(posedge mclk) disable iff (srst)
      (ram_wr_req && !in_fifo) |=> ram_wr_allow)
      else $error("ram write below buffer refused");
endmodule
`default_nettype wire

// *** usbaec_host_model.sv ***
// usb host stand-in that issues tokens and ends transactions
`timescale 1ns/1ps
`default_nettype none
module usbaec_host_model (
   input  wire logic                      mclk,
   output var  usbaec_pkg::usbaec_token_t tok,
   output var  logic                      setup_data_start,
   output var  logic                      xact_done,
   output var  logic                      xact_acked
);
   import usbaec_pkg::*;
   initial begin
      {tok, setup_data_start, xact_done, xact_acked} = '0;
   end
   // token, data phase strobe for setup, end after gap cycles; call at a falling edge
   task automatic send(input usbaec_pid_t p, input logic [6:0] a, input logic [1:0] e, input logic k, input int gap);
      tok <= '{1'b1, p, a, e};
      @(negedge mclk);
      tok <= '{1'b0, p, ~a, ~e}; // idle address and endpoint never keep the last value
      setup_data_start <= (p == USBAEC_PID_SETUP);
      @(negedge mclk);
      setup_data_start <= 1'b0;
      repeat (gap) @(negedge mclk);
      xact_done <= 1'b1;
      xact_acked <= k;
      @(negedge mclk);
      xact_done <= 1'b0;
      xact_acked <= ~k; // meaningless away from the end strobe
      @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// *** test_usb_address_and_ep0_control.sv ***
// self-checking bench for the usb address and control endpoint logic
`timescale 1ns/1ps
`default_nettype none
module test_usb_address_and_ep0_control;
   import usbaec_pkg::*;
   logic          mclk, srst, usb_bus_reset, io_wr, ram_wr_req, ram_wr_allow;
   logic          tok_match, setup_data_start, xact_done, xact_acked;
   logic [7:0]    io_addr, io_wdata, io_rdata, ram_addr;
   logic [1:0]    tok_endp;
   logic [6:0]    dev;
   usbaec_token_t tok;
   usbaec_hs_t    hs;
   logic [5:0]    exp_q[$];
   int            mismatches, checks, seed;
   usbaec_core u_usbaec_core (.mclk(mclk), .srst(srst), .usb_bus_reset(usb_bus_reset), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rdata(io_rdata), .ram_addr(ram_addr), .ram_wr_req(ram_wr_req),
      .ram_wr_allow(ram_wr_allow), .tok(tok), .setup_data_start(setup_data_start), .xact_done(xact_done),
      .xact_acked(xact_acked), .hs(hs), .tok_match(tok_match), .tok_endp(tok_endp));
   usbaec_host_model u_usbaec_host_model (.mclk(mclk), .tok(tok), .setup_data_start(setup_data_start),
      .xact_done(xact_done), .xact_acked(xact_acked));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic report_and_stop;
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_allow(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: write allow %b expected %b", $time, got, exp);
      end
   endtask
   // token reply packed as endpoint, match, valid, ack, nak
   task automatic cmp_hs(input logic [5:0] got, input logic [5:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: token reply %b expected %b", $time, got, exp);
      end
   endtask
   // bus tasks start and end at a falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(negedge mclk);
      io_wr <= 1'b0;
      @(negedge mclk); // idle cycle so back to back writes never retoggle the strobe in one step
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      io_addr <= a;
      @(negedge mclk);
      cmp(io_rdata, e);
   endtask
   task automatic ram(input logic [7:0] a, input logic e);
      ram_addr <= a;
      ram_wr_req <= 1'b1;
      @(negedge mclk);
      ram_wr_req <= 1'b0;
      cmp_allow(ram_wr_allow, e);
      @(negedge mclk);
   endtask
   // any match or handshake pulse consumes the oldest expectation
   always @(negedge mclk) begin
      if (srst === 1'b0 && (tok_match !== 1'b0 || hs.valid !== 1'b0)) begin
         if (exp_q.size() == 0) cmp_hs(6'h00, 6'h3F);
         else cmp_hs({tok_endp, tok_match, hs}, exp_q.pop_front());
      end
   end
   // hang guard, far beyond the real run length
   initial begin
      repeat (3000) @(posedge mclk);
      mismatches++;
      report_and_stop();
   end
   initial begin
      seed = 11595;
      {usb_bus_reset, io_wr, ram_wr_req, io_addr, io_wdata, ram_addr} = '0;
      srst = 1'b1;
      repeat (6) @(negedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      rd(8'h10, 8'h00);
      rd(8'h12, 8'h00);
      rd(8'h11, 8'h00);
      dev = 7'(1 + {$random(seed)} % 127);
      wr(8'h10, {1'b0, dev});
      wr(8'h10, {1'b1, dev});
      rd(8'h10, {1'b1, dev});
      wr(8'h12, 8'h01);
      rd(8'h12, 8'h01);
      for (int i = 0; i < 2; i++) begin
         exp_q.push_back(6'b001101);
         u_usbaec_host_model.send(usbaec_pid_t'(i), dev, 2'h0, 1'b0, 1);
      end
      rd(8'h12, 8'h01);
      exp_q.push_back(6'b001110);
      // mode register and buffer writes race the setup data phase and must lose
      fork
         u_usbaec_host_model.send(USBAEC_PID_SETUP, dev, 2'h0, 1'b1, 10);
         begin
            repeat (3) @(negedge mclk);
            wr(8'h12, 8'h00);
            rd(8'h12, 8'h81);
            ram(8'hF8, 1'b0);
            ram(8'hFF, 1'b0);
            ram(8'hF7, 1'b1);
         end
      join
      rd(8'h12, 8'h91);
      wr(8'h12, {4'($random(seed)), 4'h1});
      rd(8'h12, 8'h01);
      ram(8'hF8, 1'b1);
      wr(8'h12, 8'h00);
      for (int i = 0; i < 2; i++) begin
         exp_q.push_back(6'b001000);
         u_usbaec_host_model.send(usbaec_pid_t'(i), dev, 2'h0, 1'b1, 0);
         rd(8'h12, (i == 0) ? 8'h30 : 8'h50);
         wr(8'h12, 8'h00);
      end
      exp_q.push_back(6'b001000);
      u_usbaec_host_model.send(USBAEC_PID_OUT, dev, 2'h0, 1'b0, 0);
      rd(8'h12, 8'h00);
      for (int i = 1; i < 4; i++) begin
         if (i < 3) exp_q.push_back({2'(i), 4'b1000});
         u_usbaec_host_model.send(USBAEC_PID_IN, dev, 2'(i), 1'b0, 0);
      end
      u_usbaec_host_model.send(USBAEC_PID_IN, dev ^ 7'h01, 2'h0, 1'b0, 0);
      wr(8'h10, {1'b0, dev});
      u_usbaec_host_model.send(USBAEC_PID_IN, dev, 2'h0, 1'b0, 0);
      wr(8'h12, 8'h01);
      wr(8'h12, 8'h05);
      rd(8'h12, 8'h00);
      wr(8'h10, {1'b1, dev});
      wr(8'h12, 8'h01);
      usb_bus_reset <= 1'b1;
      @(negedge mclk);
      usb_bus_reset <= 1'b0;
      rd(8'h10, 8'h00);
      rd(8'h12, 8'h00);
      cmp(8'(exp_q.size()), 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
